// ==== logic/ioc_pkg.sv ====
// constants and types shared by the oscillator control block
package ioc_pkg;
    // register addresses in register space
    localparam logic [7:0] IOC_LF_CTRL_ADDR = 8'hAD;
    localparam logic [7:0] IOC_HF_CTRL_ADDR = 8'hB7;
    localparam logic [7:0] IOC_HF_TRIM_ADDR = 8'hBF;
    localparam logic [7:0] IOC_SRC_SEL_ADDR = 8'h8F;
    // control register field positions
    localparam int IOC_ON_BIT      = 7;
    localparam int IOC_RDY_BIT     = 6;
    localparam int IOC_SUSP_BIT    = 5;
    localparam int IOC_TUNE_LSB    = 2;
    // reset values
    localparam logic [7:0] IOC_HF_CTRL_RESET = 8'hC0;
    localparam logic [7:0] IOC_TRIM_RESET    = 8'h80;
    localparam logic [3:0] IOC_TUNE_RESET    = 4'h8;
    localparam logic [1:0] IOC_DIV8          = 2'h0;
    // system clock source codes
    localparam logic [2:0] IOC_SRC_HF  = 3'h0;
    localparam logic [2:0] IOC_SRC_EXT = 3'h1;
    localparam logic [2:0] IOC_SRC_LF  = 3'h2;
    localparam logic [2:0] IOC_SRC_PLL = 3'h4;
    // positions in the synchronised input vector
    localparam int IOC_NSYNC  = 11;
    localparam int IOC_I_HF   = 0;
    localparam int IOC_I_LF   = 1;
    localparam int IOC_I_EXT  = 2;
    localparam int IOC_I_PLL  = 3;
    localparam int IOC_I_HFST = 4;
    localparam int IOC_I_LFST = 5;
    localparam int IOC_I_P0   = 6;
    localparam int IOC_I_P1   = 7;
    localparam int IOC_I_P2   = 8;
    localparam int IOC_I_C0   = 9;
    localparam int IOC_I_C1   = 10;
    // high-frequency oscillator state
    typedef enum logic [2:0] {
        IOC_RUN  = 3'b001,
        IOC_SUSP = 3'b010,
        IOC_WAKE = 3'b100
    } ioc_state_t;
endpackage

// ==== logic/ioc_divider.sv ====
// post-divider that only switches ratio at a period boundary
module ioc_divider
    import ioc_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    // undivided oscillator edge and ratio code
    input  wire logic       edge_in,
    input  wire logic [1:0] div_sel,
    // one pulse per divided period
    output logic            tick_out
);
    // divider state
    typedef struct packed {
        logic [2:0] cnt;   // edges left in this period
        logic       tick;  // divided period pulse
    } ioc_div_t;

    ioc_div_t q;       // registered state
    ioc_div_t next_q;  // next state

    // count down, reload with the new ratio only at wrap
    always_comb
    begin
        next_q = q;
        next_q.tick = 1'b0;
        if (edge_in)
        begin
            if (q.cnt == 3'h0)
            begin
                next_q.tick = 1'b1;
                next_q.cnt = 3'((4'h8 >> div_sel) - 4'h1);
            end
            else
            begin
                next_q.cnt = q.cnt - 3'h1;
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            q <= '0;
        else
            q <= next_q;
    end

    assign tick_out = q.tick;

    // no divided pulse part way through a period
    mid_period_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (edge_in && q.cnt != 3'h0) |=> !tick_out)
        else $error("divided tick inside a period");
endmodule

// ==== logic/ioc_osc_ctrl.sv ====
// control of the internal high- and low-frequency oscillators
// What this block does
// - reset selects high-frequency oscillator as clock
// - trim register sets period, factory reset
// - high divider codes give eight four two one
// - control bit seven enables high oscillator
// - ready flag set only at programmed frequency
// - suspend write stops core and peripheral clocks while the high source is selected
// - wake resumes clocks, execution continues after
// - reserved control bits read zero, written zero
// - low divider codes give eight four two one
// - low control bit seven enables oscillator
// - low ready flag set once stable
// - fine tune zero fastest, fifteen slowest
// - low register resets clear, tune loads default
// - low edges capture timer counts into reloads
// - high control register resets to C0
// - source select chooses system clock origin
module ioc_osc_ctrl
    import ioc_pkg::*;
#(
    parameter logic [7:0] TRIM_RESET = IOC_TRIM_RESET,
    parameter logic [3:0] TUNE_RESET = IOC_TUNE_RESET
)
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // register access
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  sfr_wdata,
    output logic [7:0]       sfr_rdata,
    // oscillator and clock pins, asynchronous
    input  wire logic        hf_osc_clk,
    input  wire logic        lf_osc_clk,
    input  wire logic        ext_osc_clk,
    input  wire logic        pll_clk,
    input  wire logic        hf_osc_stable,
    input  wire logic        lf_osc_stable,
    // oscillator controls
    output logic             hf_osc_run,
    output logic [7:0]       hf_trim_out,
    output logic             lf_osc_run,
    output logic [3:0]       lf_tune_out,
    // wake sources
    input  wire logic        port0_match,
    input  wire logic        port1_match,
    input  wire logic        port2_match,
    input  wire logic        cmp0_enable,
    input  wire logic        cmp0_out,
    input  wire logic        cmp1_enable,
    input  wire logic        cmp1_out,
    // system clock
    output logic [2:0]       clock_source_select,
    output logic             system_clock_tick,
    output logic             core_clock_run,
    // timer capture
    input  wire logic        timer2_capture_mode,
    input  wire logic        timer3_capture_mode,
    input  wire logic [15:0] timer2_count,
    input  wire logic [15:0] timer3_count,
    output logic [15:0]      timer2_reload_value,
    output logic [15:0]      timer3_reload_value,
    output logic             timer2_capture,
    output logic             timer3_capture
);
    // all block state
    typedef struct packed {
        logic [IOC_NSYNC-1:0] s1;    // first sync stage
        logic [IOC_NSYNC-1:0] s2;    // second sync stage
        logic [IOC_NSYNC-1:0] s3;    // previous, for edges
        ioc_state_t           st;    // high oscillator state
        logic                 hf_on; // high enable
        logic                 hf_rdy;// high ready flag
        logic [1:0]           hf_div;// high divider code
        logic [7:0]           trim;  // high trim
        logic                 lf_on; // low enable
        logic                 lf_rdy;// low ready flag
        logic [3:0]           tune;  // low fine tune
        logic [1:0]           lf_div;// low divider code
        logic [2:0]           src;   // system clock source
        logic [7:0]           rdata; // read data
        logic [15:0]          t2rl;  // timer 2 capture
        logic [15:0]          t3rl;  // timer 3 capture
        logic                 t2cap; // timer 2 capture pulse
        logic                 t3cap; // timer 3 capture pulse
    } ioc_state_s_t;

    ioc_state_s_t q;       // registered state
    ioc_state_s_t next_q;  // next state

    logic [IOC_NSYNC-1:0] pins;     // raw asynchronous inputs
    logic [IOC_NSYNC-1:0] rise;     // synced rising edges
    logic                 hf_tick;  // divided high pulse
    logic                 lf_tick;  // divided low pulse
    logic                 wake_ev;  // any wake source
    logic                 halted;   // core clocks stopped
    logic                 sel_tick; // selected source pulse
    logic                 wr_hf;    // write to high control
    logic                 lf_fall;  // low oscillator falling edge

    // gather pins for the synchroniser
    assign pins[IOC_I_HF]   = hf_osc_clk;
    assign pins[IOC_I_LF]   = lf_osc_clk;
    assign pins[IOC_I_EXT]  = ext_osc_clk;
    assign pins[IOC_I_PLL]  = pll_clk;
    assign pins[IOC_I_HFST] = hf_osc_stable;
    assign pins[IOC_I_LFST] = lf_osc_stable;
    assign pins[IOC_I_P0]   = port0_match;
    assign pins[IOC_I_P1]   = port1_match;
    assign pins[IOC_I_P2]   = port2_match;
    assign pins[IOC_I_C0]   = cmp0_out;
    assign pins[IOC_I_C1]   = cmp1_out;

    // edges only from the second stage onward
    assign rise    = q.s2 & ~q.s3;
    assign lf_fall = q.s3[IOC_I_LF] & ~q.s2[IOC_I_LF];

    assign wake_ev = q.s2[IOC_I_P0] | q.s2[IOC_I_P1] | q.s2[IOC_I_P2]
                   | (cmp0_enable & ~q.s2[IOC_I_C0])
                   | (cmp1_enable & ~q.s2[IOC_I_C1]);

    // high oscillator post-divider, fed only while it runs
    ioc_divider u_hf_div (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .edge_in  (rise[IOC_I_HF] & hf_osc_run),
        .div_sel  (q.hf_div),
        .tick_out (hf_tick)
    );

    // low oscillator post-divider
    ioc_divider u_lf_div (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .edge_in  (rise[IOC_I_LF] & q.lf_on),
        .div_sel  (q.lf_div),
        .tick_out (lf_tick)
    );

    // source multiplexer, reserved codes give no clock
    always_comb
    begin
        case (q.src)
            IOC_SRC_HF:  sel_tick = hf_tick;
            IOC_SRC_EXT: sel_tick = rise[IOC_I_EXT];
            IOC_SRC_LF:  sel_tick = lf_tick;
            IOC_SRC_PLL: sel_tick = rise[IOC_I_PLL];
            default:     sel_tick = 1'b0;
        endcase
    end

    // clocks stop while suspended on the high source
    assign halted = (q.st != IOC_RUN) && (q.src == IOC_SRC_HF);
    assign wr_hf  = sfr_wr && (sfr_addr == IOC_HF_CTRL_ADDR);

    // next state of the whole block
    always_comb
    begin
        next_q = q;
        // two-stage sync plus edge history
        next_q.s1 = pins;
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
        next_q.t2cap = 1'b0;
        next_q.t3cap = 1'b0;

        // suspend sequencing
        case (q.st)
            IOC_RUN:
            begin
                if (wr_hf && sfr_wdata[IOC_SUSP_BIT])
                    next_q.st = IOC_SUSP;
            end
            IOC_SUSP:
            begin
                if (wake_ev)
                    next_q.st = IOC_WAKE;
            end
            IOC_WAKE:
            begin
                if (q.s2[IOC_I_HFST] || !q.hf_on)
                    next_q.st = IOC_RUN;
            end
            default:
            begin
                next_q.st = IOC_RUN;
            end
        endcase

        next_q.hf_rdy = q.hf_on && (q.st == IOC_RUN) && q.s2[IOC_I_HFST];
        // ready once low oscillator is stable
        next_q.lf_rdy = q.lf_on && q.s2[IOC_I_LFST];

        // register writes, ignored while the core is halted
        if (sfr_wr && !halted)
        begin
            case (sfr_addr)
                IOC_HF_CTRL_ADDR:
                begin
                    next_q.hf_on  = sfr_wdata[IOC_ON_BIT];
                    next_q.hf_div = sfr_wdata[1:0];
                end
                IOC_HF_TRIM_ADDR:
                begin
                    next_q.trim = sfr_wdata;
                end
                IOC_LF_CTRL_ADDR:
                begin
                    next_q.lf_on  = sfr_wdata[IOC_ON_BIT];
                    next_q.tune   = sfr_wdata[IOC_TUNE_LSB +: 4];
                    next_q.lf_div = sfr_wdata[1:0];
                end
                IOC_SRC_SEL_ADDR:
                begin
                    next_q.src = sfr_wdata[2:0];
                end
                default:
                begin
                    next_q.src = q.src;
                end
            endcase
        end

        // register reads, registered one cycle later
        if (sfr_rd)
        begin
            case (sfr_addr)
                IOC_HF_CTRL_ADDR: next_q.rdata = {q.hf_on, q.hf_rdy,
                                                  q.st != IOC_RUN, 3'h0, q.hf_div};
                IOC_HF_TRIM_ADDR: next_q.rdata = q.trim;
                IOC_LF_CTRL_ADDR: next_q.rdata = {q.lf_on, q.lf_rdy,
                                                  q.tune, q.lf_div};
                IOC_SRC_SEL_ADDR: next_q.rdata = {5'h00, q.src};
                default:          next_q.rdata = 8'h00;
            endcase
        end

        if (timer2_capture_mode && lf_fall)
        begin
            next_q.t2rl  = timer2_count;
            next_q.t2cap = 1'b1;
        end
        if (timer3_capture_mode && rise[IOC_I_LF])
        begin
            next_q.t3rl  = timer3_count;
            next_q.t3cap = 1'b1;
        end
    end

    // state register with reset values
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            q        <= '0;
            q.st     <= IOC_RUN;
            // high oscillator stable syncs start high, low stays clear
            // keeps ready at one on the first edges after release
            q.s1[IOC_I_HFST] <= 1'b1;
            q.s2[IOC_I_HFST] <= 1'b1;
            q.s3[IOC_I_HFST] <= 1'b1;
            q.hf_on  <= IOC_HF_CTRL_RESET[IOC_ON_BIT];
            q.hf_rdy <= IOC_HF_CTRL_RESET[IOC_RDY_BIT];
            q.hf_div <= IOC_DIV8;
            q.trim   <= TRIM_RESET;
            q.tune   <= TUNE_RESET;
            // high oscillator drives the system clock
            q.src    <= IOC_SRC_HF;
        end
        else
        begin
            q <= next_q;
        end
    end

    // outputs
    assign sfr_rdata           = q.rdata;
    assign hf_osc_run          = q.hf_on && (q.st != IOC_SUSP);
    assign hf_trim_out         = q.trim;
    assign lf_osc_run          = q.lf_on;
    assign lf_tune_out         = q.tune;
    assign clock_source_select = q.src;
    assign core_clock_run      = !halted;
    assign system_clock_tick   = sel_tick && !halted;
    assign timer2_reload_value = q.t2rl;
    assign timer3_reload_value = q.t3rl;
    assign timer2_capture      = q.t2cap;
    assign timer3_capture      = q.t3cap;

    // checks
    reset_source_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $fell(sys_rst) |-> (clock_source_select == IOC_SRC_HF))
        else $error("source not high oscillator after reset");
    hf_reset_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $fell(sys_rst) |-> (q.hf_on && q.hf_div == IOC_DIV8 && q.st == IOC_RUN))
        else $error("high control reset value wrong");
    trim_write_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (sfr_wr && !halted && sfr_addr == IOC_HF_TRIM_ADDR)
        |=> (hf_trim_out == $past(sfr_wdata)))
        else $error("trim write lost");
    reserved_zero_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (sfr_rd && sfr_addr == IOC_HF_CTRL_ADDR) |=> (sfr_rdata[4:2] == 3'h0))
        else $error("reserved bits not zero");
    clock_halt_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (wr_hf && sfr_wdata[IOC_SUSP_BIT] && q.st == IOC_RUN
         && clock_source_select == IOC_SRC_HF)
        |=> (!core_clock_run && !system_clock_tick && !hf_osc_run))
        else $error("clocks run during suspend");
    wake_event_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (q.st == IOC_SUSP && wake_ev) |=> (q.st == IOC_WAKE) ##1 (q.st != IOC_SUSP))
        else $error("wake event missed");
    hf_ready_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (q.st != IOC_RUN) |=> !q.hf_rdy)
        else $error("ready while not running");
    lf_ready_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !q.lf_on |=> !q.lf_rdy)
        else $error("low ready while disabled");
    capture_t2_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (timer2_capture_mode && lf_fall)
        |=> (timer2_capture && timer2_reload_value == $past(timer2_count)))
        else $error("timer 2 capture wrong");
    suspend_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
        q.st == IOC_RUN ##1 q.st == IOC_SUSP);
    resume_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
        q.st == IOC_WAKE ##1 q.st == IOC_RUN);
    capture_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
        timer3_capture);
endmodule

// ==== testbench/testbench.sv ====
// self-checking bench for the oscillator control block
module testbench
    import ioc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // clock, reset and register access
    logic        ref_clk = 1'b0, sys_rst = 1'b1;
    logic        sfr_wr = 1'b0, sfr_rd = 1'b0;
    logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
    // oscillator pins, free running and unrelated to ref_clk
    logic        hf_osc_clk = 1'b0, lf_osc_clk = 1'b0, ext_osc_clk = 1'b0, pll_clk = 1'b0;
    logic        hf_osc_stable = 1'b1, lf_osc_stable = 1'b1;
    // wake sources, idle levels
    logic        port0_match = 1'b0, port1_match = 1'b0, port2_match = 1'b0;
    logic        cmp0_enable = 1'b0, cmp0_out = 1'b1, cmp1_enable = 1'b0, cmp1_out = 1'b1;
    // timer side
    logic        timer2_capture_mode = 1'b0, timer3_capture_mode = 1'b0;
    logic [15:0] timer2_count = 16'h1234, timer3_count = 16'hABCD;
    // design outputs
    logic        hf_osc_run, lf_osc_run, system_clock_tick, core_clock_run;
    logic        timer2_capture, timer3_capture;
    logic [7:0]  hf_trim_out;
    logic [3:0]  lf_tune_out;
    logic [2:0]  clock_source_select;
    logic [15:0] timer2_reload_value, timer3_reload_value;
    // bookkeeping
    int          err_count = 0, samples_checked = 0, tick_cnt = 0, i, k;
    // source codes and their pin periods in ns, zero for no clock
    localparam logic [2:0] SRCS [5] = '{IOC_SRC_HF, IOC_SRC_EXT, IOC_SRC_LF, IOC_SRC_PLL, 3'h3};
    localparam int         PERS [5] = '{40, 56, 152, 72, 0};

    // clocks
    always #4 ref_clk = ~ref_clk;
    always #20 hf_osc_clk = ~hf_osc_clk;
    always #76 lf_osc_clk = ~lf_osc_clk;
    always #28 ext_osc_clk = ~ext_osc_clk;
    always #36 pll_clk = ~pll_clk;

    // counts system clock ticks
    always @(posedge ref_clk)
        if (system_clock_tick === 1'b1)
            tick_cnt <= tick_cnt + 1;

    ioc_osc_ctrl ioc_osc_ctrl_inst (
        .ref_clk, .sys_rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
        .hf_osc_clk, .lf_osc_clk, .ext_osc_clk, .pll_clk, .hf_osc_stable, .lf_osc_stable,
        .hf_osc_run, .hf_trim_out, .lf_osc_run, .lf_tune_out,
        .port0_match, .port1_match, .port2_match,
        .cmp0_enable, .cmp0_out, .cmp1_enable, .cmp1_out,
        .clock_source_select, .system_clock_tick, .core_clock_run,
        .timer2_capture_mode, .timer3_capture_mode, .timer2_count, .timer3_count,
        .timer2_reload_value, .timer3_reload_value, .timer2_capture, .timer3_capture
    );

    // verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // one comparison
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // write strobe for one cycle
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        sfr_addr  = a;
        sfr_wdata = d;
        sfr_wr    = 1'b1;
        @(negedge ref_clk);
        sfr_wr    = 1'b0;
    endtask

    // read strobe for one cycle, data one cycle later
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_rd   = 1'b1;
        @(negedge ref_clk);
        sfr_rd   = 1'b0;
        chk(what, {8'h00, exp}, {8'h00, sfr_rdata});
    endtask

    // ticks over a window against the edges of the source pin
    task automatic rate(input string what, input int per, input int shift);
        int t0;
        int exp;
        int tol;
        idle(200);
        t0  = tick_cnt;
        idle(1216);
        exp = (per == 0) ? 0 : ((1216 * 8 / per) >> shift);
        tol = (exp > 0) ? 2 : 0;
        samples_checked++;
        if ((tick_cnt - t0) > exp + tol || (tick_cnt - t0) + tol < exp)
        begin
            $display("mismatch %s expected %0d seen %0d", what, exp, tick_cnt - t0);
            err_count++;
        end
    endtask

    // raise or drop one wake source
    task automatic set_wake(input int n, input logic v);
        case (n)
            0: port0_match = v;
            1: port1_match = v;
            2: port2_match = v;
            3: cmp0_enable = v;
            default: cmp1_enable = v;
        endcase
        if (n == 3)
            cmp0_out = ~v;
        if (n == 4)
            cmp1_out = ~v;
    endtask

    // reset held 16 cycles, then defaults read back
    task automatic reset_and_check();
        sys_rst = 1'b1;
        idle(16);
        sys_rst = 1'b0;
        rd_chk("hf_ctrl_reset", IOC_HF_CTRL_ADDR, IOC_HF_CTRL_RESET);
        rd_chk("lf_ctrl_reset", IOC_LF_CTRL_ADDR, {2'b00, IOC_TUNE_RESET, 2'b00});
        rd_chk("src_reset", IOC_SRC_SEL_ADDR, 8'h00);
        chk("src_out_reset", 16'h0000, {13'h0000, clock_source_select});
        chk("core_run_reset", 16'h0001, {15'h0000, core_clock_run});
    endtask

    // main sequence
    initial
    begin
        reset_and_check();
        rd_chk("trim_reset", IOC_HF_TRIM_ADDR, IOC_TRIM_RESET);
        reg_wr(IOC_HF_TRIM_ADDR, 8'h5A);
        rd_chk("trim_write", IOC_HF_TRIM_ADDR, 8'h5A);
        chk("trim_out", 16'h005A, {8'h00, hf_trim_out});
        reg_wr(IOC_HF_CTRL_ADDR, 8'h83);
        idle(4);
        rd_chk("hf_reserved", IOC_HF_CTRL_ADDR, 8'hC3);
        rd_chk("unmapped", 8'h00, 8'h00);
        reg_wr(IOC_HF_CTRL_ADDR, 8'h03);
        idle(4);
        chk("hf_run_off", 16'h0000, {15'h0000, hf_osc_run});
        rd_chk("hf_off_ready", IOC_HF_CTRL_ADDR, 8'h03);
        reg_wr(IOC_HF_CTRL_ADDR, 8'h83);
        hf_osc_stable = 1'b0;
        idle(6);
        chk("hf_run_on", 16'h0001, {15'h0000, hf_osc_run});
        rd_chk("hf_unstable", IOC_HF_CTRL_ADDR, 8'h83);
        hf_osc_stable = 1'b1;
        idle(6);
        rd_chk("hf_stable", IOC_HF_CTRL_ADDR, 8'hC3);
        $display("test hf registers done");
        reg_wr(IOC_LF_CTRL_ADDR, 8'hBF);
        lf_osc_stable = 1'b0;
        idle(6);
        chk("lf_run_on", 16'h0001, {15'h0000, lf_osc_run});
        chk("lf_tune_slow", 16'h000F, {12'h000, lf_tune_out});
        rd_chk("lf_unstable", IOC_LF_CTRL_ADDR, 8'hBF);
        lf_osc_stable = 1'b1;
        idle(6);
        rd_chk("lf_stable", IOC_LF_CTRL_ADDR, 8'hFF);
        reg_wr(IOC_LF_CTRL_ADDR, 8'h03);
        idle(2);
        chk("lf_run_off", 16'h0000, {15'h0000, lf_osc_run});
        reg_wr(IOC_LF_CTRL_ADDR, 8'h83);
        idle(2);
        chk("lf_tune_fast", 16'h0000, {12'h000, lf_tune_out});
        $display("test lf registers done");
        for (k = 0; k < 5; k++)
        begin
            reg_wr(IOC_SRC_SEL_ADDR, {5'h00, SRCS[k]});
            chk("src_out", {13'h0000, SRCS[k]}, {13'h0000, clock_source_select});
            rate("source_rate", PERS[k], 0);
        end
        for (k = 0; k < 4; k++)
        begin
            reg_wr(IOC_SRC_SEL_ADDR, 8'h00);
            reg_wr(IOC_HF_CTRL_ADDR, 8'h80 | k[7:0]);
            rate("hf_divider", 40, 3 - k);
            reg_wr(IOC_SRC_SEL_ADDR, 8'h02);
            reg_wr(IOC_LF_CTRL_ADDR, 8'h80 | k[7:0]);
            rate("lf_divider", 152, 3 - k);
        end
        $display("test clock rates done");
        reg_wr(IOC_SRC_SEL_ADDR, 8'h00);
        for (k = 0; k < 5; k++)
        begin
            reg_wr(IOC_HF_CTRL_ADDR, 8'hA0);
            idle(4);
            chk("core_halted", 16'h0000, {15'h0000, core_clock_run});
            chk("hf_run_susp", 16'h0000, {15'h0000, hf_osc_run});
            i = tick_cnt;
            reg_wr(IOC_HF_TRIM_ADDR, 8'h11);
            // low comparator output without its enable
            cmp1_out = 1'b0;
            idle(40);
            chk("ticks_halted", 16'h0000, 16'(tick_cnt - i));
            chk("no_wake", 16'h0000, {15'h0000, core_clock_run});
            cmp1_out = 1'b1;
            set_wake(k, 1'b1);
            for (i = 0; i < 40 && core_clock_run !== 1'b1; i++)
                idle(1);
            chk("woken", 16'h0001, {15'h0000, core_clock_run});
            if (i == 40)
                tally_and_finish();
            set_wake(k, 1'b0);
            idle(8);
            rd_chk("hf_ctrl_woken", IOC_HF_CTRL_ADDR, 8'hC0);
            rd_chk("trim_held", IOC_HF_TRIM_ADDR, 8'h5A);
        end
        $display("test suspend and wake done");
        timer2_capture_mode = 1'b1;
        for (i = 0; i < 100 && timer2_capture !== 1'b1; i++)
            idle(1);
        chk("t2_capture", 16'h0001, {15'h0000, timer2_capture});
        chk("t2_falling", 16'h0000, {15'h0000, lf_osc_clk});
        chk("t2_reload", timer2_count, timer2_reload_value);
        if (i == 100)
            tally_and_finish();
        timer3_capture_mode = 1'b1;
        for (i = 0; i < 100 && timer3_capture !== 1'b1; i++)
            idle(1);
        chk("t3_capture", 16'h0001, {15'h0000, timer3_capture});
        chk("t3_rising", 16'h0001, {15'h0000, lf_osc_clk});
        chk("t3_reload", timer3_count, timer3_reload_value);
        if (i == 100)
            tally_and_finish();
        $display("test capture done");
        reset_and_check();
        rate("reset_rate", 40, 3);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule
